// ### hw/ssc_pkg.sv
// Package: register map, field positions and reset values of the serial status block
package ssc_pkg;
	// ---------------------------------------------------------------
	// Register byte addresses
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_STATUS   = 8'h00;
	localparam logic [7:0] ADDR_CTRL_ONE = 8'h04;
	localparam logic [7:0] ADDR_CTRL_TWO = 8'h08;
	localparam logic [7:0] ADDR_DATA     = 8'h0C;
	localparam logic [7:0] ADDR_MODE     = 8'h10;
	// ---------------------------------------------------------------
	// Status bit positions
	// ---------------------------------------------------------------
	localparam int ST_TXE = 7;
	localparam int ST_TXC = 6;
	localparam int ST_RXR = 5;
	localparam int ST_IDL = 4;
	localparam int ST_OVR = 3;
	localparam int ST_NSE = 2;
	localparam int ST_FRM = 1;
	localparam int ST_PAR = 0;
	// ---------------------------------------------------------------
	// Control one bit positions
	// ---------------------------------------------------------------
	localparam int C1_RX9     = 7;
	localparam int C1_TX9     = 6;
	localparam int C1_LPD     = 5;
	localparam int C1_LEN     = 4;
	localparam int C1_WAKE    = 3;
	localparam int C1_PAR_ON  = 2;
	localparam int C1_ODD     = 1;
	localparam int C1_PAR_IEN = 0;
	// ---------------------------------------------------------------
	// Control two bit positions (enables) and mode register bits
	// ---------------------------------------------------------------
	localparam int C2_TXE_IEN = 7;
	localparam int C2_TXC_IEN = 6;
	localparam int C2_RX_IEN  = 5;
	localparam int C2_IDL_IEN = 4;
	localparam int MD_LIN     = 0;
	localparam int MD_LIN_PAR = 1;
	// ---------------------------------------------------------------
	// Reset values and AXI response codes
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_STATUS = 8'hC0;
	localparam logic [7:0] RST_CTRL   = 8'h00;
	localparam logic [1:0] AXI_OKAY   = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// ### hw/ssc_status_ctrl.sv
// Serial interface status flags, first control register and interrupt
`timescale 1ns/1ps
module ssc_status_ctrl (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Core side
	input  wire logic        global_irq_mask,
	input  wire logic        wait_mode,
	input  wire logic        halt_mode,
	output logic             irq_req,
	output logic             wait_wakeup,
	// Datapath strobes, same clock
	input  wire logic        tx_load_evt,
	input  wire logic        tx_done_evt,
	input  wire logic        tx_done_special,
	input  wire logic        rx_word_evt,
	input  wire logic [8:0]  rx_word,
	input  wire logic        rx_noise,
	input  wire logic        rx_framing,
	input  wire logic        rx_parity_err,
	input  wire logic        idle_evt,
	input  wire logic        byte_boundary,
	// Datapath controls
	output logic [8:0]       tx_word,
	output logic             tx_word_valid,
	output logic             nine_bit_mode,
	output logic             parity_check_en,
	output logic             parity_gen_en,
	output logic             parity_odd_active,
	output logic             wake_address_mark,
	output logic             header_detect_method,
	output logic             link_run
);
	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [7:0] status_q;
	logic [7:0] ctrl1_q;
	logic [7:0] ctrl2_q;
	logic [1:0] mode_q;
	logic [7:0] rx_buf_q;
	logic [7:0] armed_q;
	logic       idle_armed_q;
	logic       parity_odd_q;
	logic       run_q;
	logic [7:0] awaddr_q;
	logic       aw_have_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic       w_have_q;
	logic [8:0] tx_word_q;
	logic       tx_word_valid_q;
	logic wr_fire;
	logic rd_fire;
	logic [7:0] wr_addr;
	logic [7:0] rd_addr;
	logic wr_data_reg;
	logic rd_data_reg;
	logic rd_status;
	logic active;
	logic [7:0] set_d;
	logic [7:0] clr_d;
	logic [7:0] evt_en;
	// ---------------------------------------------------------------
	// AXI4-Lite handshake
	// ---------------------------------------------------------------
	assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign wr_addr = awaddr_q;
	assign rd_addr = s_axi_araddr;
	always_ff @(posedge clk) begin
		if (reset) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_have_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_have_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= ssc_pkg::AXI_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			case (wr_addr)
				ssc_pkg::ADDR_STATUS, ssc_pkg::ADDR_CTRL_ONE,
				ssc_pkg::ADDR_CTRL_TWO, ssc_pkg::ADDR_DATA,
				ssc_pkg::ADDR_MODE: s_axi_bresp <= ssc_pkg::AXI_OKAY;
				default: s_axi_bresp <= ssc_pkg::AXI_SLVERR;
			endcase
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= ssc_pkg::AXI_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= ssc_pkg::AXI_OKAY;
			case (rd_addr)
				ssc_pkg::ADDR_STATUS:   s_axi_rdata <= {24'h0, status_q};
				ssc_pkg::ADDR_CTRL_ONE: s_axi_rdata <= {24'h0, ctrl1_q};
				ssc_pkg::ADDR_CTRL_TWO: s_axi_rdata <= {24'h0, ctrl2_q};
				ssc_pkg::ADDR_DATA:     s_axi_rdata <= {24'h0, rx_buf_q};
				ssc_pkg::ADDR_MODE:     s_axi_rdata <= {30'h0, mode_q};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= ssc_pkg::AXI_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	assign wr_data_reg = wr_fire && wr_addr == ssc_pkg::ADDR_DATA && wstrb_q[0];
	assign rd_data_reg = rd_fire && rd_addr == ssc_pkg::ADDR_DATA;
	// Status is read-only; a write to it still counts as an access
	assign rd_status = (rd_fire && rd_addr == ssc_pkg::ADDR_STATUS) ||
		(wr_fire && wr_addr == ssc_pkg::ADDR_STATUS);

	// ---------------------------------------------------------------
	// Control registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl1_q <= ssc_pkg::RST_CTRL;
			ctrl2_q <= ssc_pkg::RST_CTRL;
			mode_q  <= 2'h0;
		end else begin
			if (wr_fire && wstrb_q[0]) begin
				// Received ninth bit stays hardware-owned
				if (wr_addr == ssc_pkg::ADDR_CTRL_ONE)
					ctrl1_q[6:0] <= wdata_q[6:0];
				if (wr_addr == ssc_pkg::ADDR_CTRL_TWO)
					ctrl2_q <= wdata_q[7:0];
				if (wr_addr == ssc_pkg::ADDR_MODE)
					mode_q <= wdata_q[1:0];
			end
			// Halt freezes the receiver, so no ninth bit is captured
			if (rx_word_evt && !status_q[ssc_pkg::ST_RXR] && !halt_mode)
				ctrl1_q[ssc_pkg::C1_RX9] <= ctrl1_q[ssc_pkg::C1_LEN] ?
					rx_word[8] : 1'b0;
		end
	end

	assign nine_bit_mode     = ctrl1_q[ssc_pkg::C1_LEN];
	// relied upon: length changes only between transfers
	assign parity_check_en   = ctrl1_q[ssc_pkg::C1_PAR_ON];
	assign parity_gen_en     = ctrl1_q[ssc_pkg::C1_PAR_ON] &&
		!mode_q[ssc_pkg::MD_LIN_PAR];
	assign wake_address_mark = !mode_q[ssc_pkg::MD_LIN] &&
		ctrl1_q[ssc_pkg::C1_WAKE];
	assign header_detect_method = mode_q[ssc_pkg::MD_LIN] &&
		ctrl1_q[ssc_pkg::C1_WAKE];

	// Parity sense and low-power stop only move on a byte boundary
	always_ff @(posedge clk) begin
		if (reset) begin
			parity_odd_q <= 1'b0;
			run_q        <= 1'b1;
		end else if (byte_boundary) begin
			parity_odd_q <= ctrl1_q[ssc_pkg::C1_ODD];
			run_q        <= !ctrl1_q[ssc_pkg::C1_LPD];
		end
	end
	assign parity_odd_active = parity_odd_q;
	assign active   = run_q && !halt_mode;
	assign link_run = active;

	// ---------------------------------------------------------------
	// Transmit word
	// ---------------------------------------------------------------
	function automatic logic par7(input logic [6:0] d, input logic odd);
		par7 = ^d ^ odd;
	endfunction
	function automatic logic par8(input logic [7:0] d, input logic odd);
		par8 = ^d ^ odd;
	endfunction

	always_ff @(posedge clk) begin
		if (reset) begin
			tx_word_q       <= 9'h000;
			tx_word_valid_q <= 1'b0;
		end else begin
			tx_word_valid_q <= wr_data_reg;
			if (wr_data_reg) begin
				tx_word_q <= {ctrl1_q[ssc_pkg::C1_TX9], wdata_q[7:0]};
				if (parity_gen_en) begin
					if (ctrl1_q[ssc_pkg::C1_LEN])
						tx_word_q[8] <= par8(wdata_q[7:0],
							parity_odd_q);
					else
						tx_word_q[7] <= par7(wdata_q[6:0],
							parity_odd_q);
				end
			end
		end
	end
	assign tx_word       = tx_word_q;
	assign tx_word_valid = tx_word_valid_q;

	// ---------------------------------------------------------------
	// Status flags
	// ---------------------------------------------------------------
	logic rx_take;
	logic rx_over;
	assign rx_take = active && rx_word_evt && !status_q[ssc_pkg::ST_RXR];
	assign rx_over = active && rx_word_evt && status_q[ssc_pkg::ST_RXR];

	always_comb begin
		set_d = 8'h00;
		set_d[ssc_pkg::ST_TXE] = active && tx_load_evt;
		set_d[ssc_pkg::ST_TXC] = active && tx_done_evt &&
			!tx_done_special;
		set_d[ssc_pkg::ST_RXR] = rx_take;
		set_d[ssc_pkg::ST_IDL] = active && idle_evt && idle_armed_q;
		set_d[ssc_pkg::ST_OVR] = rx_over;
		set_d[ssc_pkg::ST_NSE] = rx_take && rx_noise;
		set_d[ssc_pkg::ST_FRM] = rx_take && rx_framing;
		set_d[ssc_pkg::ST_PAR] = rx_take && rx_parity_err &&
			ctrl1_q[ssc_pkg::C1_PAR_ON];
	end

	// Flags seen at a status access are armed for the next data access
	always_ff @(posedge clk) begin
		if (reset)
			armed_q <= 8'h00;
		else if (rd_status)
			armed_q <= status_q;
		else if (wr_data_reg || rd_data_reg)
			armed_q <= 8'h00;
	end

	always_comb begin
		clr_d = 8'h00;
		if (wr_data_reg)
			clr_d[7:6] = armed_q[7:6];
		if (rd_data_reg)
			clr_d[5:0] = armed_q[5:0];
		if (wr_data_reg || rd_data_reg)
			clr_d[ssc_pkg::ST_PAR] = armed_q[ssc_pkg::ST_PAR];
	end

	// Set beats clear so an event in the clearing cycle survives
	always_ff @(posedge clk) begin
		if (reset)
			status_q <= ssc_pkg::RST_STATUS;
		else
			status_q <= (status_q & ~clr_d) | set_d;
	end

	always_ff @(posedge clk) begin
		if (reset)
			idle_armed_q <= 1'b1;
		else if (set_d[ssc_pkg::ST_RXR])
			idle_armed_q <= 1'b1;
		else if (set_d[ssc_pkg::ST_IDL])
			idle_armed_q <= 1'b0;
	end

	// Overrun keeps the buffered word; the new one is dropped
	always_ff @(posedge clk) begin
		if (reset)
			rx_buf_q <= 8'h00;
		else if (rx_take)
			rx_buf_q <= rx_word[7:0];
	end

	// ---------------------------------------------------------------
	// Interrupt and wake
	// ---------------------------------------------------------------
	always_comb begin
		evt_en = 8'h00;
		evt_en[ssc_pkg::ST_TXE] = ctrl2_q[ssc_pkg::C2_TXE_IEN];
		evt_en[ssc_pkg::ST_TXC] = ctrl2_q[ssc_pkg::C2_TXC_IEN];
		evt_en[ssc_pkg::ST_RXR] = ctrl2_q[ssc_pkg::C2_RX_IEN];
		evt_en[ssc_pkg::ST_IDL] = ctrl2_q[ssc_pkg::C2_IDL_IEN];
		evt_en[ssc_pkg::ST_OVR] = ctrl2_q[ssc_pkg::C2_RX_IEN];
		evt_en[ssc_pkg::ST_PAR] = ctrl1_q[ssc_pkg::C1_PAR_IEN] &&
			ctrl1_q[ssc_pkg::C1_PAR_ON];
	end

	logic irq_any;
	assign irq_any = |(status_q & evt_en);
	assign irq_req = irq_any && !global_irq_mask;
	// Halt wake is left to other sources
	assign wait_wakeup = irq_req && wait_mode && !halt_mode;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	AST_IRQ_MASK: assert property (@(posedge clk) disable iff (reset)
		global_irq_mask |-> !irq_req) else $error("irq while masked");
	AST_WAIT_WAKE: assert property (@(posedge clk) disable iff (reset)
		(wait_mode && !halt_mode && !global_irq_mask && status_q[7] &&
		ctrl2_q[7]) |-> wait_wakeup) else $error("no wait wake");
	AST_HALT: assert property (@(posedge clk) disable iff (reset)
		halt_mode |-> !wait_wakeup && !link_run) else $error("halt wake");
	AST_TXE_SET: assert property (@(posedge clk) disable iff (reset)
		(tx_load_evt && run_q && !halt_mode) |=> status_q[7])
		else $error("tx empty not set");
	AST_TC_SPECIAL: assert property (@(posedge clk) disable iff (reset)
		(tx_done_special && !status_q[6]) |=> !status_q[6])
		else $error("complete set by idle/break");
	AST_RXR_SET: assert property (@(posedge clk) disable iff (reset)
		rx_take |=> status_q[5] && rx_buf_q == $past(rx_word[7:0]))
		else $error("ready not set");
	// Helper: an idle set has happened and no word has come in since
	logic idle_seen_q;
	always_ff @(posedge clk)
		idle_seen_q <= !reset && !rx_take && (idle_seen_q || set_d[4]);
	AST_IDLE_ONCE: assert property (@(posedge clk) disable iff (reset)
		(idle_seen_q && !rx_take) |-> !set_d[4]) else $error("idle rearmed");
	AST_OVR_KEEP: assert property (@(posedge clk) disable iff (reset)
		rx_over |=> status_q[3] && $stable(rx_buf_q))
		else $error("overrun lost buffer");
	AST_FRM_OVR: assert property (@(posedge clk) disable iff (reset)
		(rx_over && rx_framing && !status_q[1]) |=> !status_q[1])
		else $error("framing set with overrun");
	AST_CLR_SEQ: assert property (@(posedge clk) disable iff (reset)
		(rd_data_reg && armed_q[5] && !rx_take) |=> !status_q[5])
		else $error("ready not cleared");
	AST_PAR_EN: assert property (@(posedge clk) disable iff (reset)
		(status_q[0] && !ctrl1_q[0] && !(|(status_q[7:1] & evt_en[7:1])))
		|-> !irq_req) else $error("parity irq not gated");
	COV_OVERRUN: cover property (@(posedge clk) rx_take ##[1:20] rx_over);
	COV_CLEAR:   cover property (@(posedge clk) rd_status ##[1:10] rd_data_reg);
	COV_TXCLR:   cover property (@(posedge clk) rd_status ##[1:10] wr_data_reg);
	COV_WAKE:    cover property (@(posedge clk) wait_wakeup);
endmodule

// ### tb/sci_status_control_irq_tb.sv
// Self-checking bench for the serial status and control block
`timescale 1ns/1ps
module sci_status_control_irq_tb;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic        clk = 1'b0, reset = 1'b1;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, v, w, d;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, r;
	logic        mask = 1'b0, wt = 1'b0, hlt = 1'b0, irq, wake;
	logic        tl, td, tds, rxe, rn, rf, rp, ie, bb;
	logic [8:0]  rw, txw;
	logic        txv, nine, pchk, pgen, podd, wam, hdm, run;
	int          num_errors = 0, checked = 0, cyc = 0, txv_cnt = 0, nt = 0;
	initial forever #12.5 clk = ~clk;
	ssc_status_ctrl i_dut (.clk(clk), .reset(reset),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.global_irq_mask(mask), .wait_mode(wt), .halt_mode(hlt),
		.irq_req(irq), .wait_wakeup(wake), .tx_load_evt(tl),
		.tx_done_evt(td), .tx_done_special(tds), .rx_word_evt(rxe),
		.rx_word(rw), .rx_noise(rn), .rx_framing(rf),
		.rx_parity_err(rp), .idle_evt(ie), .byte_boundary(bb),
		.tx_word(txw), .tx_word_valid(txv), .nine_bit_mode(nine),
		.parity_check_en(pchk), .parity_gen_en(pgen),
		.parity_odd_active(podd), .wake_address_mark(wam),
		.header_detect_method(hdm), .link_run(run));
	ssc_link_model i_link (.clk(clk), .tx_load_evt(tl), .tx_done_evt(td),
		.tx_done_special(tds), .rx_word_evt(rxe), .rx_word(rw),
		.rx_noise(rn), .rx_framing(rf), .rx_parity_err(rp),
		.idle_evt(ie), .byte_boundary(bb));
	// ---------------------------------------------------------------
	// Bus and check tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED at %0t: saw %h, wanted %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] dd,
		output logic [1:0] rs);
		logic ta, tw, fa, fw;
		@(posedge clk);
		awaddr <= a;
		wdata <= dd;
		{awvalid, wvalid, bready} <= 3'h7;
		ta = 1'b1;
		tw = 1'b1;
		while (ta || tw) begin
			@(negedge clk);
			fa = ta && awready;
			fw = tw && wready;
			@(posedge clk);
			if (fa) begin
				awvalid <= 1'b0;
				ta = 1'b0;
			end
			if (fw) begin
				wvalid <= 1'b0;
				tw = 1'b0;
			end
		end
		do @(negedge clk); while (bvalid !== 1'b1);
		rs = bresp;
		@(posedge clk);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] dd,
		output logic [1:0] rs);
		@(posedge clk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do @(negedge clk); while (arready !== 1'b1);
		@(posedge clk);
		arvalid <= 1'b0;
		do @(negedge clk); while (rvalid !== 1'b1);
		dd = rdata;
		rs = rresp;
		@(posedge clk);
		rready <= 1'b0;
	endtask
	task automatic wrt(input logic [7:0] a, input logic [31:0] dd);
		wr(a, dd, r);
		@(negedge clk);
	endtask
	task automatic stat(input logic [31:0] e);
		rd(ssc_pkg::ADDR_STATUS, v, r);
		chk(v, e);
	endtask
	// Status access then data read; the word read stays in v
	task automatic clr_r;
		rd(ssc_pkg::ADDR_STATUS, v, r);
		rd(ssc_pkg::ADDR_DATA, v, r);
	endtask
	task automatic clr_w;
		rd(ssc_pkg::ADDR_STATUS, v, r);
		wrt(ssc_pkg::ADDR_DATA, 32'h00);
	endtask
	function automatic logic [8:0] par(input logic [7:0] x, input logic o);
		return {1'b0, (^x[6:0]) ^ o, x[6:0]};
	endfunction
	task automatic done(input string n);
		$display("Test %s finished", n);
	endtask
	task automatic report_and_stop;
		$display("Comparisons %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Hang guard, well above the few hundred cycles the run needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		// Count transmit-word strobes; each must stand one cycle only
		if (txv === 1'b1)
			txv_cnt <= txv_cnt + 1;
		if (cyc == 8000) begin
			num_errors++;
			report_and_stop;
		end
	end
	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	initial begin
		void'($urandom(5));
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		stat(32'hC0);
		rd(ssc_pkg::ADDR_CTRL_ONE, v, r);
		chk(v, 32'h00);
		rd(8'h14, v, r);
		chk(r, ssc_pkg::AXI_SLVERR);
		wr(8'h14, 32'hFF, r);
		chk(r, ssc_pkg::AXI_SLVERR);
		wrt(ssc_pkg::ADDR_CTRL_TWO, 32'h80);
		chk(irq, 1'b1);
		@(posedge clk);
		mask <= 1'b1;
		@(negedge clk);
		chk(irq, 1'b0);
		@(posedge clk);
		{mask, wt} <= 2'h1;
		@(negedge clk);
		chk(wake, 1'b1);
		@(posedge clk);
		hlt <= 1'b1;
		@(negedge clk);
		chk(wake, 1'b0);
		chk(run, 1'b0);
		i_link.pulse(3, 9'h0A5, 3'h0);
		{wt, hlt} <= 2'h0;
		stat(32'hC0);
		done("reset_irq");
		clr_w;
		stat(32'h00);
		chk(irq, 1'b0);
		i_link.pulse(0, 9'h0, 3'h0);
		stat(32'h80);
		chk(irq, 1'b1);
		i_link.pulse(2, 9'h0, 3'h0);
		stat(32'h80);
		i_link.pulse(1, 9'h0, 3'h0);
		stat(32'hC0);
		// Only flags present at the status access may clear
		w = $urandom & 32'hFF;
		rd(ssc_pkg::ADDR_STATUS, v, r);
		i_link.pulse(3, w[8:0], 3'h0);
		rd(ssc_pkg::ADDR_DATA, v, r);
		stat(32'hE0);
		clr_r;
		chk(v, w);
		stat(32'hC0);
		done("tx_flags");
		wrt(ssc_pkg::ADDR_CTRL_TWO, 32'h10);
		for (int i = 0; i < 4; i++) begin
			w = $urandom & 32'hFF;
			i_link.pulse(3, w[8:0], {i[1:0], 1'b0});
			stat(32'hE0 | (i[1:0] << 1));
			chk(irq, 1'b0);
			clr_r;
			chk(v, w);
		end
		d = $urandom & 32'hFF;
		i_link.pulse(3, w[8:0], 3'h0);
		i_link.pulse(3, d[8:0], 3'h2);
		stat(32'hE8);
		rd(ssc_pkg::ADDR_DATA, v, r);
		chk(v, w);
		stat(32'hC0);
		i_link.pulse(4, 9'h0, 3'h0);
		stat(32'hD0);
		chk(irq, 1'b1);
		clr_r;
		i_link.pulse(4, 9'h0, 3'h0);
		stat(32'hC0);
		i_link.pulse(3, w[8:0], 3'h0);
		i_link.pulse(4, 9'h0, 3'h0);
		stat(32'hF0);
		clr_r;
		done("receive");
		wrt(ssc_pkg::ADDR_CTRL_ONE, 32'h05);
		chk({pgen, pchk}, 2'h3);
		i_link.pulse(3, w[8:0], 3'h1);
		stat(32'hE1);
		chk(irq, 1'b1);
		clr_w;
		stat(32'h20);
		clr_r;
		wrt(ssc_pkg::ADDR_DATA, d);
		chk(txw, par(d[7:0], 1'b0));
		wrt(ssc_pkg::ADDR_CTRL_ONE, 32'h07);
		chk(podd, 1'b0);
		wrt(ssc_pkg::ADDR_DATA, d);
		chk(txw, par(d[7:0], 1'b0));
		i_link.pulse(5, 9'h0, 3'h0);
		@(negedge clk);
		chk(podd, 1'b1);
		wrt(ssc_pkg::ADDR_DATA, d);
		chk(txw, par(d[7:0], 1'b1));
		wrt(ssc_pkg::ADDR_MODE, 32'h03);
		chk({pgen, pchk}, 2'h1);
		i_link.pulse(3, w[8:0], 3'h1);
		@(negedge clk);
		chk(irq, 1'b1);
		clr_w;
		clr_r;
		wrt(ssc_pkg::ADDR_CTRL_ONE, 32'h0D);
		chk(hdm, 1'b1);
		wrt(ssc_pkg::ADDR_MODE, 32'h00);
		chk(wam, 1'b1);
		done("parity");
		// Length changes only while the link carries nothing
		wrt(ssc_pkg::ADDR_CTRL_ONE, 32'h50);
		chk(nine, 1'b1);
		i_link.pulse(3, 9'h100 | w[8:0], 3'h0);
		rd(ssc_pkg::ADDR_CTRL_ONE, v, r);
		chk(v, 32'hD0);
		nt = txv_cnt;
		wrt(ssc_pkg::ADDR_DATA, d);
		chk(txw, {1'b1, d[7:0]});
		chk(txv_cnt - nt, 32'h1);
		clr_r;
		wrt(ssc_pkg::ADDR_CTRL_ONE, 32'h20);
		chk(run, 1'b1);
		i_link.pulse(5, 9'h0, 3'h0);
		@(negedge clk);
		chk(run, 1'b0);
		i_link.pulse(3, w[8:0], 3'h0);
		stat(32'h00);
		wrt(ssc_pkg::ADDR_CTRL_ONE, 32'h00);
		i_link.pulse(5, 9'h0, 3'h0);
		@(negedge clk);
		chk(run, 1'b1);
		done("nine_power");
		report_and_stop;
	end
endmodule

// ### tb/ssc_link_model.sv
// Datapath-side model: raises the transfer and receive strobes of the block
`timescale 1ns/1ps
module ssc_link_model (
	// Clock
	input  wire logic clk,
	// Strobes toward the block
	output logic       tx_load_evt,
	output logic       tx_done_evt,
	output logic       tx_done_special,
	output logic       rx_word_evt,
	output logic [8:0] rx_word,
	output logic       rx_noise,
	output logic       rx_framing,
	output logic       rx_parity_err,
	output logic       idle_evt,
	output logic       byte_boundary
);
	initial begin
		{tx_load_evt, tx_done_evt, tx_done_special, rx_word_evt} = 4'h0;
		{rx_noise, rx_framing, rx_parity_err} = 3'h7;
		{idle_evt, byte_boundary} = 2'h0;
		rx_word = 9'h1FF;
	end
	// ---------------------------------------------------------------
	// Kinds: 0 load, 1 data frame done, 2 idle or break done,
	// 3 received word, 4 idle line, 5 byte end
	// ---------------------------------------------------------------
	task automatic pulse(input int k, input logic [8:0] w,
		input logic [2:0] q);
		@(posedge clk);
		tx_load_evt <= (k == 0);
		tx_done_evt <= (k == 1) || (k == 2);
		tx_done_special <= (k == 2);
		rx_word_evt <= (k == 3);
		rx_word <= w;
		{rx_noise, rx_framing, rx_parity_err} <= q;
		idle_evt <= (k == 4);
		byte_boundary <= (k == 5);
		@(posedge clk);
		{tx_load_evt, tx_done_evt, tx_done_special, rx_word_evt} <= 4'h0;
		{idle_evt, byte_boundary} <= 2'h0;
		// Released lines show the inverse so stale values never match
		rx_word <= ~w;
		{rx_noise, rx_framing, rx_parity_err} <= ~q;
	endtask
endmodule
